// >>> logic/slt_ctrl.sv
// slt_ctrl: slate mic, tone oscillator and talk back control and routing
// What this block does
// - slate press toggles; hold one second is momentary
// - yellow led when slate or tone latched
// - active slate mutes program, feeds all outputs
// - optional one second 400 hz pre-tone
// - slate disable makes slate side do nothing except the knob-with-slate gain step
// - tone press activates; two second hold latches
// - default tone is 1 khz at reference level
// - tone level and frequency are configurable
// - headphones attenuated while tone active
// - battery press toggles left output -20 db cycling
// - talk back slate only to headphone right
// - talk back: big phones program, small selectable
// - four small headphone source options
// - small headphone gain set by controller with slate
// - battery plus slate gives all-call normal slate
// - slate disable also blocks all-call
// - talk back selection shown on left meter zero
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`include "slt_map.svh"
module slt_ctrl #(
  parameter int unsigned P_SLATE_HOLD = `SLT_SLATE_HOLD_MS * (`SLT_CLK_HZ / 1000),
  parameter int unsigned P_TONE_HOLD  = `SLT_TONE_HOLD_MS * (`SLT_CLK_HZ / 1000),
  parameter int unsigned P_PRETONE    = `SLT_PRETONE_MS * (`SLT_CLK_HZ / 1000),
  parameter int unsigned P_CYCLE      = `SLT_CYCLE_MS * (`SLT_CLK_HZ / 1000),
  parameter int          P_DEPTH      = 8
) (
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rstn,
  // avalon-mm register slave
  input  wire logic [3:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  input  wire logic [3:0]         i_avs_byteenable,
  output logic [31:0]             o_avs_readdata,
  output logic                    o_avs_waitrequest,
  // front panel
  input  wire logic               i_sw_slate,
  input  wire logic               i_sw_tone,
  input  wire logic               i_batt_btn,
  input  wire logic               i_hp_step,
  input  wire logic               i_hp_up,
  output logic                    o_led_yellow,
  output logic                    o_meter_zero_led,
  // sample stream in
  input  wire logic               i_in_valid,
  input  wire logic [63:0]        i_in_data,
  output logic                    o_in_ready,
  // sample stream out
  output logic                    o_out_valid,
  input  wire logic               i_out_ready,
  output logic signed [15:0]      o_main_l,
  output logic signed [15:0]      o_main_r,
  output logic signed [15:0]      o_direct,
  output logic signed [15:0]      o_rec_l,
  output logic signed [15:0]      o_rec_r,
  output logic signed [15:0]      o_hp_big_l,
  output logic signed [15:0]      o_hp_big_r,
  output logic signed [15:0]      o_hp_small_l,
  output logic signed [15:0]      o_hp_small_r
);
  // counters wide enough for the longest hold
  localparam int CW = 32;

  // register file
  logic [4:0]  ctrl_q;              // config bits
  logic [31:0] tone_q;              // level high half, phase step low half
  logic [7:0]  gain_q;              // small headphone gain, 0x80 is unity
  logic        ack_q;               // bus answer phase
  // switch handling
  slt_pkg::slt_state_t state_q, state_d;
  logic [CW-1:0] hold_q;            // time in current state
  logic        sl_prev_q;           // edge detect on slate side
  logic        tn_prev_q;           // edge detect on tone side
  logic        bt_prev_q;           // edge detect on battery button
  logic [CW-1:0] pre_q;             // pre-tone time left
  logic        cyc_q;               // left channel cycling on
  logic        drop_q;              // left channel currently dropped
  logic [CW-1:0] per_q;             // cycling half period counter
  logic signed [15:0] tone_smp;     // oscillator output

  // config fields
  wire sl_dis  = ctrl_q[`SLT_CTRL_SL_DIS];
  wire pre_en  = ctrl_q[`SLT_CTRL_PRETONE];
  wire tb_en   = ctrl_q[`SLT_CTRL_TB_EN];
  wire slt_pkg::slt_tb_src_t tb_src = slt_pkg::slt_tb_src_t'(ctrl_q[`SLT_CTRL_TB_SRC +: 2]);

  // panel edges
  wire sl_rise = i_sw_slate & ~sl_prev_q;
  wire tn_rise = i_sw_tone & ~tn_prev_q;
  wire bt_rise = i_batt_btn & ~bt_prev_q;

  // activity decode
  wire sl_act   = (state_q == slt_pkg::ST_SL_PRESS) | (state_q == slt_pkg::ST_SL_LATCH);
  wire tn_act   = (state_q == slt_pkg::ST_TN_PRESS) | (state_q == slt_pkg::ST_TN_LATCH);
  wire allcall  = tb_en & sl_act & i_batt_btn & ~sl_dis;
  wire sl_norm  = sl_act & (~tb_en | allcall);
  wire sl_talk  = sl_act & tb_en & ~allcall;
  wire pre_on   = (pre_q != '0);

  // bus decode
  wire req      = i_avs_read | i_avs_write;
  wire wr_take  = i_avs_write & ack_q;
  wire hit_ctrl = (i_avs_address == `SLT_CTRL_OFS);
  wire hit_tone = (i_avs_address == `SLT_TONE_OFS);
  wire hit_gain = (i_avs_address == `SLT_GAIN_OFS);
  wire hit_stat = (i_avs_address == `SLT_STAT_OFS);
  wire [31:0] be_m = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] stat_w = {21'h0, drop_q, cyc_q, pre_on, allcall, o_led_yellow, state_q};
  wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
                       hit_tone ? tone_q :
                       hit_gain ? {24'h0, gain_q} :
                       hit_stat ? stat_w : 32'h0;
  wire [31:0] tone_w = (tone_q & ~be_m) | (i_avs_writedata & be_m);

  // one wait cycle on every access, answer on the second edge
  assign o_avs_waitrequest = req & ~ack_q;

  // indicators
  assign o_led_yellow     = (state_q == slt_pkg::ST_SL_LATCH) |
                            (state_q == slt_pkg::ST_TN_LATCH);
  assign o_meter_zero_led = tb_en;

  // bus answer and read data
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_q          <= 1'b0;
      o_avs_readdata <= '0;
    end else begin
      ack_q <= req & ~ack_q;
      if (i_avs_read & ~ack_q) o_avs_readdata <= rd_mux;
    end
  end

  // config registers; a bus write to gain overrides a knob step in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= `SLT_CTRL_RST;
      tone_q <= `SLT_TONE_RST;
      gain_q <= `SLT_GAIN_RST;
    end else begin
      if (wr_take & hit_ctrl & i_avs_byteenable[0]) ctrl_q <= i_avs_writedata[4:0];
      if (wr_take & hit_tone) tone_q <= tone_w;
      // knob turn while slate held sets boom feed level
      if (tb_en & i_sw_slate & i_hp_step) begin
        if (i_hp_up & (gain_q < `SLT_GAIN_MAX)) gain_q <= gain_q + 8'h01;
        else if (~i_hp_up & (gain_q != 8'h00)) gain_q <= gain_q - 8'h01;
      end
      if (wr_take & hit_gain & i_avs_byteenable[0]) gain_q <= i_avs_writedata[7:0];
    end
  end

  // switch state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      slt_pkg::ST_IDLE: begin
        if (sl_rise & ~sl_dis) state_d = slt_pkg::ST_SL_PRESS;
        else if (tn_rise) state_d = slt_pkg::ST_TN_PRESS;
      end
      slt_pkg::ST_SL_PRESS: begin
        if (sl_dis) state_d = slt_pkg::ST_IDLE;
        else if (tn_rise) state_d = slt_pkg::ST_TN_PRESS;
        else if (!i_sw_slate) begin
          // long hold means momentary, short press latches
          state_d = (hold_q >= CW'(P_SLATE_HOLD)) ? slt_pkg::ST_IDLE
                                                  : slt_pkg::ST_SL_LATCH;
        end
      end
      slt_pkg::ST_SL_LATCH: begin
        if (sl_dis) state_d = slt_pkg::ST_IDLE;
        else if (tn_rise) state_d = slt_pkg::ST_TN_PRESS;
        else if (sl_rise) state_d = slt_pkg::ST_WAIT_REL;
      end
      slt_pkg::ST_TN_PRESS: begin
        if (sl_rise & ~sl_dis) state_d = slt_pkg::ST_SL_PRESS;
        else if (!i_sw_tone) state_d = slt_pkg::ST_IDLE;
        else if (hold_q >= CW'(P_TONE_HOLD)) state_d = slt_pkg::ST_TN_LATCH;
      end
      slt_pkg::ST_TN_LATCH: begin
        if (sl_rise & ~sl_dis) state_d = slt_pkg::ST_SL_PRESS;
        else if (tn_rise) state_d = slt_pkg::ST_WAIT_REL;
      end
      slt_pkg::ST_WAIT_REL: begin
        // turning off ends only once the switch is back at centre
        if (!i_sw_slate & !i_sw_tone) state_d = slt_pkg::ST_IDLE;
      end
      default: state_d = slt_pkg::ST_IDLE;
    endcase
  end

  // state, hold timer and panel edges
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q   <= slt_pkg::ST_IDLE;
      hold_q    <= '0;
      sl_prev_q <= 1'b0;
      tn_prev_q <= 1'b0;
      bt_prev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      hold_q    <= (state_d != state_q) ? '0 : (hold_q == '1 ? hold_q : hold_q + 1'b1);
      sl_prev_q <= i_sw_slate;
      tn_prev_q <= i_sw_tone;
      bt_prev_q <= i_batt_btn;
    end
  end

  // pre-tone timer starts on each slate activation
  wire sl_start = (state_d == slt_pkg::ST_SL_PRESS) & (state_q != slt_pkg::ST_SL_PRESS);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) pre_q <= '0;
    else if (sl_start & pre_en) pre_q <= CW'(P_PRETONE);
    else if (!sl_act) pre_q <= '0;
    else if (pre_on) pre_q <= pre_q - 1'b1;
  end

  // left channel cycling; tone off always ends it
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cyc_q  <= 1'b0;
      drop_q <= 1'b0;
      per_q  <= '0;
    end else if (!tn_act) begin
      cyc_q  <= 1'b0;
      drop_q <= 1'b0;
      per_q  <= '0;
    end else begin
      if (bt_rise) cyc_q <= ~cyc_q;
      if (!cyc_q | bt_rise) begin
        drop_q <= 1'b0;
        per_q  <= '0;
      end else if (per_q >= CW'(P_CYCLE - 1)) begin
        drop_q <= ~drop_q;
        per_q  <= '0;
      end else begin
        per_q  <= per_q + 1'b1;
      end
    end
  end

  // sample stream: fifo in front of the router
  slt_strm_if #(.W(64)) q_if ();
  slt_fifo #(
    .W (64),
    .D (P_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_valid   (i_in_valid),
    .i_data    (i_in_data),
    .o_ready   (o_in_ready),
    .o_q       (q_if.src)
  );
  // output register stalls the fifo when downstream holds off
  assign q_if.ready = i_out_ready | ~o_out_valid;
  wire take = q_if.valid & q_if.ready;
  slt_pkg::slt_smp_t smp;
  assign smp = slt_pkg::slt_smp_t'(q_if.data);

  // oscillator, forced to 400 hz during pre-tone
  slt_tone u_tone (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_adv     (take),
    .i_step    (pre_on ? `SLT_PRETONE_STEP : tone_q[15:0]),
    .i_level   (tone_q[31:16]),
    .o_smp     (tone_smp)
  );

  // half-sum mix never overflows
  function automatic logic signed [15:0] mix(input logic signed [15:0] a,
                                              input logic signed [15:0] b);
    mix = (a >>> 1) + (b >>> 1);
  endfunction
  // gain scaling, 0x80 unity; values above unity are clamped
  function automatic logic signed [15:0] scl(input logic signed [15:0] x,
                                              input logic [7:0] g);
    logic signed [24:0] p;
    p   = x * $signed({1'b0, (g > `SLT_GAIN_MAX) ? `SLT_GAIN_MAX : g});
    scl = p[22:7];
  endfunction
  // -20 db drop for the cycling left output
  function automatic logic signed [15:0] drp(input logic signed [15:0] x);
    logic signed [32:0] p;
    p   = x * $signed({1'b0, `SLT_DROP_MUL});
    drp = p[30:15];
  endfunction

  // routed samples
  wire signed [15:0] slate_s = pre_on ? tone_smp : smp.slate;
  wire signed [15:0] main_l  = sl_norm ? slate_s :
                               tn_act  ? (drop_q ? drp(tone_smp) : tone_smp) :
                               smp.prog_l;
  wire signed [15:0] main_r  = sl_norm ? slate_s : tn_act ? tone_smp : smp.prog_r;
  wire signed [15:0] dir_s   = sl_norm ? slate_s : tn_act ? tone_smp : smp.ch1;
  // big phones follow program; talk back slate rides on the right only
  wire signed [15:0] hpb_l   = tn_act ? (main_l >>> `SLT_HP_ATT) : main_l;
  wire signed [15:0] hpb_r0  = tn_act ? (main_r >>> `SLT_HP_ATT) : main_r;
  wire signed [15:0] hpb_r   = sl_talk ? mix(hpb_r0, slate_s) : hpb_r0;
  wire signed [15:0] tb_sl   = sl_talk ? slate_s : 16'sh0000;
  // small phones picked by the talk back source while in talk back
  logic signed [15:0] hps_l, hps_r;
  always_comb begin
    hps_l = hpb_l;
    hps_r = hpb_r;
    if (tb_en & ~allcall) begin
      unique case (tb_src)
        slt_pkg::TB_OFF: begin
          hps_l = hpb_l;
          hps_r = hpb_r;
        end
        slt_pkg::TB_SLATE: begin
          hps_l = 16'sh0000;
          hps_r = tb_sl;
        end
        slt_pkg::TB_LEFT: begin
          hps_l = smp.prog_l;
          hps_r = mix(smp.prog_l, tb_sl);
        end
        slt_pkg::TB_CH1: begin
          hps_l = smp.ch1;
          hps_r = mix(smp.ch1, tb_sl);
        end
      endcase
      hps_l = scl(hps_l, gain_q);
      hps_r = scl(hps_r, gain_q);
    end
  end

  // output sample register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_out_valid  <= 1'b0;
      o_main_l     <= '0;
      o_main_r     <= '0;
      o_direct     <= '0;
      o_rec_l      <= '0;
      o_rec_r      <= '0;
      o_hp_big_l   <= '0;
      o_hp_big_r   <= '0;
      o_hp_small_l <= '0;
      o_hp_small_r <= '0;
    end else if (q_if.ready) begin
      o_out_valid  <= q_if.valid;
      if (take) begin
        o_main_l     <= main_l;
        o_main_r     <= main_r;
        o_direct     <= dir_s;
        o_rec_l      <= main_l;
        o_rec_r      <= main_r;
        o_hp_big_l   <= hpb_l;
        o_hp_big_r   <= hpb_r;
        o_hp_small_l <= hps_l;
        o_hp_small_r <= hps_r;
      end
    end
  end
endmodule // slt_ctrl

// >>> logic/slt_fifo.sv
// slt_fifo: sample fifo with plain fill side and interface drain side
`timescale 1ns/1ns
module slt_fifo #(
  parameter int W = 64,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  // fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // drain side
  slt_strm_if.src           o_q
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];            // sample storage
  logic [AW-1:0] wp_q;              // write pointer
  logic [AW-1:0] rp_q;              // read pointer
  logic [AW:0]   cnt_q;             // fill level
  wire           push = i_valid & o_ready;
  wire           pop  = o_q.valid & o_q.ready;

  assign o_ready   = (cnt_q < (AW+1)'(D));
  assign o_q.valid = (cnt_q != '0);
  assign o_q.data  = mem[rp_q];

  // storage has no reset, only pointers do
  always_ff @(posedge i_ref_clk) begin
    if (push) mem[wp_q] <= i_data;
  end

  // pointers wrap at depth
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      if (pop)  rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // slt_fifo

// >>> logic/slt_map.svh
// slt_map.svh: register offsets, field positions, reset values and timing counts
`ifndef SLT_MAP_SVH
`define SLT_MAP_SVH
// register byte offsets
`define SLT_CTRL_OFS     4'h0
`define SLT_TONE_OFS     4'h4
`define SLT_GAIN_OFS     4'h8
`define SLT_STAT_OFS     4'hc
// control field positions
`define SLT_CTRL_SL_DIS  0
`define SLT_CTRL_PRETONE 1
`define SLT_CTRL_TB_EN   2
`define SLT_CTRL_TB_SRC  3
// reset values
`define SLT_CTRL_RST     5'h00
`define SLT_TONE_RST     32'h2000_0555
`define SLT_GAIN_RST     8'h80
`define SLT_GAIN_MAX     8'h80
// tone and level constants
`define SLT_PRETONE_STEP 16'h0222
`define SLT_DROP_MUL     16'h0ccd
`define SLT_HP_ATT       2
// timing
`define SLT_CLK_HZ       20000000
`define SLT_SLATE_HOLD_MS 1000
`define SLT_TONE_HOLD_MS 2000
`define SLT_PRETONE_MS   1000
`define SLT_CYCLE_MS     500
`endif

// >>> logic/slt_pkg.sv
// slt_pkg: types shared by the slate, tone and talk back logic
package slt_pkg;
  // switch handling states
  typedef enum logic [5:0] {
    ST_IDLE     = 6'b000001,
    ST_SL_PRESS = 6'b000010,
    ST_SL_LATCH = 6'b000100,
    ST_TN_PRESS = 6'b001000,
    ST_TN_LATCH = 6'b010000,
    ST_WAIT_REL = 6'b100000
  } slt_state_t;
  // small headphone source selection
  typedef enum logic [1:0] {
    TB_OFF   = 2'h0,
    TB_SLATE = 2'h1,
    TB_LEFT  = 2'h2,
    TB_CH1   = 2'h3
  } slt_tb_src_t;
  // one incoming sample frame
  typedef struct packed {
    logic signed [15:0] prog_l;
    logic signed [15:0] prog_r;
    logic signed [15:0] ch1;
    logic signed [15:0] slate;
  } slt_smp_t;
endpackage

// >>> logic/slt_strm_if.sv
// slt_strm_if: valid/ready word stream between the fifo and the router
`timescale 1ns/1ns
interface slt_strm_if #(parameter int W = 64);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> logic/slt_tone.sv
// slt_tone: phase accumulator sine oscillator with level scaling
`timescale 1ns/1ns
module slt_tone (
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rstn,
  // control
  input  wire logic               i_adv,
  input  wire logic [15:0]        i_step,
  input  wire logic [15:0]        i_level,
  // sample out
  output logic signed [15:0]      o_smp
);
  // quarter wave magnitudes at 22.5 degree steps
  localparam logic [15:0] QTAB [5] = '{16'h0000, 16'h30fc, 16'h5a82, 16'h7642, 16'h7fff};
  logic [15:0] ph_q;                // phase accumulator
  wire  [1:0]  quad = ph_q[15:14];
  wire  [1:0]  k    = ph_q[13:12];
  wire  [2:0]  idx  = quad[0] ? 3'h4 - {1'b0, k} : {1'b0, k};
  wire  [15:0] mag  = QTAB[idx];
  wire  signed [15:0] raw = quad[1] ? -$signed(mag) : $signed(mag);
  wire  signed [32:0] prod = raw * $signed({1'b0, i_level});

  // phase and output advance once per sample
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ph_q  <= '0;
      o_smp <= '0;
    end else if (i_adv) begin
      ph_q  <= ph_q + i_step;
      o_smp <= prod[30:15];
    end
  end
endmodule // slt_tone

// >>> verification/slt_ctrl_props.sv
// slt_ctrl_props: port-level timing checks for the slate and tone block
`timescale 1ns/1ns
module slt_ctrl_props #(
  parameter int unsigned P_SLATE_HOLD = 20,
  parameter int unsigned P_TONE_HOLD  = 40
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_sw_slate,
  input wire logic        i_sw_tone,
  input wire logic        o_led_yellow,
  input wire logic        o_meter_zero_led,
  input wire logic        o_out_valid,
  input wire logic        i_out_ready,
  input wire logic signed [15:0] o_main_l,
  input wire logic signed [15:0] o_hp_small_r
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  wire        req = i_avs_read | i_avs_write; // any bus request
  logic [7:0] sl_q; // slate held cycles, saturating
  logic [7:0] tn_q; // tone held cycles, saturating
  // hold counters; saturation keeps a long hold from wrapping to zero
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sl_q <= 8'h00;
      tn_q <= 8'h00;
    end else begin
      sl_q <= i_sw_slate ? sl_q + 8'(sl_q != 8'hff) : 8'h00;
      tn_q <= i_sw_tone ? tn_q + 8'(tn_q != 8'hff) : 8'h00;
    end
  end
  a_wait_first: assert property (req && !$past(req) |-> o_avs_waitrequest)
    else $error("no wait cycle on new request");
  a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("wait longer than one cycle");
  a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
    else $error("wait without request");
  a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
    && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_meter_write: assert property ($changed(o_meter_zero_led)
    |-> $past(i_avs_write && !o_avs_waitrequest)) else $error("meter led moved alone");
  a_out_hold: assert property (o_out_valid && !i_out_ready
    |=> o_out_valid && $stable(o_main_l) && $stable(o_hp_small_r))
    else $error("output changed while stalled");
  a_led_rise: assert property ($rose(o_led_yellow)
    |-> !$past(i_sw_slate) || $past(i_sw_tone)) else $error("led lit while slate held");
  a_tone_hold: assert property ($rose(o_led_yellow) && $past(i_sw_tone)
    |-> tn_q >= P_TONE_HOLD) else $error("tone latched early");
  a_slate_moment: assert property ($fell(i_sw_slate) && sl_q > P_SLATE_HOLD + 2
    && !o_led_yellow |=> !o_led_yellow [*4]) else $error("long slate hold latched");
endmodule // slt_ctrl_props
bind slt_ctrl slt_ctrl_props #(.P_SLATE_HOLD(P_SLATE_HOLD), .P_TONE_HOLD(P_TONE_HOLD))
  slt_ctrl_props_inst (.i_ref_clk, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write,
  .o_avs_readdata, .o_avs_waitrequest, .i_sw_slate, .i_sw_tone, .o_led_yellow,
  .o_meter_zero_led, .o_out_valid, .i_out_ready, .o_main_l, .o_hp_small_r);

// >>> verification/slt_ctrl_tb_top.sv
// slt_ctrl_tb_top: register, panel and stream tests for the slate block
`timescale 1ns/1ns
module slt_ctrl_tb_top;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, iv = 1'b0, ordy = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, d;
  logic [63:0] idat = 64'h0;
  int n_fail = 0, num_checks = 0, k;
  wire sl, tn, bt, hs, hu, wrq, led, mled, irdy, ov;
  wire [31:0] rdat;
  wire signed [15:0] ml, mr, dr, rl, rr, bl, br, sml, smr;
  always #25 clk = ~clk; // 20 mhz
  slt_panel_model slt_panel_model_inst (.i_ref_clk(clk), .o_sw_slate(sl), .o_sw_tone(tn),
    .o_batt_btn(bt), .o_hp_step(hs), .o_hp_up(hu));
  // hold counts shortened so a tone latch or a momentary slate takes tens of cycles
  slt_ctrl #(.P_SLATE_HOLD(20), .P_TONE_HOLD(40), .P_PRETONE(20), .P_CYCLE(10))
    slt_ctrl_inst (.i_ref_clk(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wrq), .i_sw_slate(sl), .i_sw_tone(tn),
    .i_batt_btn(bt), .i_hp_step(hs), .i_hp_up(hu), .o_led_yellow(led),
    .o_meter_zero_led(mled), .i_in_valid(iv), .i_in_data(idat), .o_in_ready(irdy),
    .o_out_valid(ov), .i_out_ready(ordy), .o_main_l(ml), .o_main_r(mr), .o_direct(dr),
    .o_rec_l(rl), .o_rec_r(rr), .o_hp_big_l(bl), .o_hp_big_r(br), .o_hp_small_l(sml),
    .o_hp_small_r(smr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon access; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= v;
    // waitrequest and read data are taken at the same rising edge
    do @(posedge clk);
    while (wrq !== 1'b0);
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic st(input logic [31:0] e); // status after the panel settles
    repeat (3) @(posedge clk);
    bus(1'b0, 4'hc, 0);
    chk(d & 32'h7ff, e);
  endtask
  task automatic push(input logic [63:0] v); // one frame into the fifo
    @(posedge clk);
    iv   <= 1'b1;
    idat <= v;
    @(posedge clk);
    iv <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin // watchdog, far beyond the few hundred cycles used
    #(50 * 40000);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    bus(0, 4'h0, 0); chk(d, 32'h0);
    bus(0, 4'h4, 0); chk(d, 32'h2000_0555);
    bus(0, 4'h8, 0); chk(d, 32'h80);
    bus(0, 4'h6, 0); chk(d, 32'h0);
    st(32'h1);
    bus(1, 4'h4, 32'h1000_0222); bus(0, 4'h4, 0); chk(d, 32'h1000_0222);
    panel(3'b001, 5); st(32'h44);
    ordy <= 1'b1;
    push(64'h1111_2222_3333_4444);
    repeat (4) @(posedge clk);
    chk({ml, rl}, 32'h4444_4444); chk({dr, bl}, 32'h4444_4444);
    chk({mr, rr}, 32'h4444_4444); chk({br, smr}, 32'h4444_4444);
    panel(3'b001, 5); st(32'h1);
    panel(3'b001, 30); st(32'h1);
    panel(3'b010, 50); st(32'h50);
    panel(3'b100, 3); bus(0, 4'hc, 0); chk(d[9], 1'b1);
    panel(3'b001, 3); st(32'h44);
    panel(3'b001, 3); st(32'h1);
    bus(1, 4'h0, 32'h0c); @(negedge clk); chk(mled, 1'b1);
    panel(3'b001, 5);
    push(64'h1111_2222_3333_4444);
    repeat (4) @(posedge clk);
    chk({ml, sml}, 32'h1111_0000);
    chk({bl, br}, 32'h1111_3333); chk({mr, smr}, 32'h2222_4444);
    fork // one knob detent down while the slate is held
      panel(3'b001, 5);
      slt_panel_model_inst.knob(1'b0);
    join
    bus(0, 4'h8, 0); chk(d, 32'h7f);
    // pass 0: talk back with pre-tone and all-call; pass 1: slate disabled
    for (k = 0; k < 2; k++) begin
      bus(1, 4'h0, 32'h06 - k);
      fork
        panel(3'b101, 24); // past the hold time, so slate ends on release
        begin
          repeat (6) @(posedge clk);
          bus(0, 4'hc, 0);
          chk(d[8:7], (k == 0) ? 2'h3 : 2'h0);
        end
      join
      st(32'h1);
    end
    ordy <= 1'b0; k = 0;
    repeat (12) begin @(negedge clk); if (irdy === 1'b1) k++; push(64'h1); end
    chk(k, 9); // fifo of 8 plus the output register
    ordy <= 1'b1; k = 0;
    repeat (14) begin @(negedge clk); if (ov === 1'b1) k++; @(posedge clk); end
    chk(k, 9);
    print_verdict();
  end
  task automatic panel(input logic [2:0] m, input int n);
    slt_panel_model_inst.hold(m, n);
  endtask
endmodule // slt_ctrl_tb_top

// >>> verification/slt_panel_model.sv
// slt_panel_model: operator front panel switch, button and knob
`timescale 1ns/1ns
module slt_panel_model (
  // clock
  input  wire logic i_ref_clk,
  // controls toward the block
  output logic      o_sw_slate,
  output logic      o_sw_tone,
  output logic      o_batt_btn,
  output logic      o_hp_step,
  output logic      o_hp_up
);
  initial begin
    {o_sw_slate, o_sw_tone, o_batt_btn, o_hp_step, o_hp_up} = 5'h00;
  end
  // m = {battery, tone, slate}; one lever, so slate wins over tone
  task automatic hold(input logic [2:0] m, input int n);
    @(posedge i_ref_clk);
    o_sw_slate <= m[0];
    o_sw_tone  <= m[1] & ~m[0];
    o_batt_btn <= m[2];
    repeat (n) @(posedge i_ref_clk);
    {o_sw_slate, o_sw_tone, o_batt_btn} <= 3'h0; // spring return
  endtask
  // one knob detent, a single-cycle pulse
  task automatic knob(input logic up);
    @(posedge i_ref_clk);
    o_hp_step <= 1'b1;
    o_hp_up   <= up;
    @(posedge i_ref_clk);
    o_hp_step <= 1'b0;
  endtask
endmodule // slt_panel_model
